/* File: pkg/lhp_consts.vh */
// lhp_consts.vh: constants shared by the character display host register port
// assumes inclusion by bare name from the register port, the only design file of the block that uses it
`ifndef LHP_CONSTS_VH
`define LHP_CONSTS_VH

`define LHP_DATA_W 8
`define LHP_PTR_W 7
`define LHP_CHAR_AW 7
`define LHP_GLYPH_AW 6
`define LHP_CHAR_DEPTH 80
`define LHP_GLYPH_DEPTH 64
`define LHP_CHAR_DEPTH_8 8'h50
`define LHP_CHAR_LAST 7'h4f
`define LHP_GLYPH_LAST 7'h3f
`define LHP_PTR_ZERO 7'h00
`define LHP_PTR_ONE 7'h01
`define LHP_BYTE_ZERO 8'h00
`define LHP_BUSY_BIT 7
`define LHP_CMD_CHAR_BIT 7
`define LHP_CMD_GLYPH_BIT 6
`define LHP_EXEC_CYCLES 4
`define LHP_STORE_CYCLES 3
`define LHP_CNT_W 8

`endif

/* File: verilog/lhp_fifo2.v */
// lhp_fifo2: two-entry buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
module lhp_fifo2 #(
  parameter W = 8
) (
  input wire clk_sys,
  input wire rst,
  input wire [W-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [W-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [W-1:0] slot0;
  reg [W-1:0] slot1;
  reg wrIdx;
  reg rdIdx;
  reg [1:0] count;
  wire push;
  wire pop;

  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = rdIdx ? slot1 : slot0;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always @(posedge clk_sys) begin
    if (rst) begin
      slot0 <= {W{1'b0}};
      slot1 <= {W{1'b0}};
      wrIdx <= 1'b0;
      rdIdx <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        if (wrIdx)
          slot1 <= inData;
        else
          slot0 <= inData;
        wrIdx <= ~wrIdx;
      end
      if (pop)
        rdIdx <= ~rdIdx;
      if (push & ~pop)
        count <= count + 2'h1;
      else if (pop & ~push)
        count <= count - 2'h1;
    end
  end
endmodule

/* File: verilog/lhp_mem.v */
// lhp_mem: flip-flop byte memory, one write port, two asynchronous read ports
// assumes one clock; reads beyond the depth return zero
module lhp_mem #(
  parameter W = 8,
  parameter AW = 7,
  parameter DEPTH = 80
) (
  input wire clk_sys,
  input wire rst,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [W-1:0] wrData,
  input wire [AW-1:0] rdAddrA,
  output wire [W-1:0] rdDataA,
  input wire [AW-1:0] rdAddrB,
  output wire [W-1:0] rdDataB
);
  reg [W-1:0] cells [0:DEPTH-1];
  integer i;

  assign rdDataA = (rdAddrA < DEPTH) ? cells[rdAddrA] : {W{1'b0}};
  assign rdDataB = (rdAddrB < DEPTH) ? cells[rdAddrB] : {W{1'b0}};

  always @(posedge clk_sys) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1)
        cells[i] <= {W{1'b0}};
    end else if (wrEn && (wrAddr < DEPTH)) begin
      cells[wrAddr] <= wrData;
    end
  end
endmodule

/* File: verilog/lhp_register_port.v */
// lhp_register_port: host register port of a character display controller
// assumes host pins are asynchronous to clk_sys and are synchronised here
// Function
// RULE_01: two byte registers, a command latch and a data staging latch.
// RULE_02: command latch is write only; reads with select low give status.
// RULE_03: a host data write is stored into the selected memory internally.
// RULE_04: setting an address fetches that memory byte into the staging latch.
// RULE_05: after a host data read the next address byte is prefetched.
// RULE_06: select 0, write: command latch takes the byte and executes.
// RULE_07: select 0, read: a status byte is returned.
// RULE_08: select 1, write: staging latch takes the byte, then memory.
// RULE_09: select 1, read: staging latch contents are driven to the host.
// RULE_10: while busy the flag reads 1 and commands are refused.
// RULE_11: host must see the flag at 0 before the next command.
// RULE_12: status byte holds the flag on bit 7, pointer on bits 6..0.
// RULE_13: address setting loads the pointer and selects the target memory.
// RULE_14: pointer steps by plus or minus one after each data access.
// RULE_15: character memory holds 80 bytes, all usable as storage.
// RULE_16: first display position shows address 00, then successive ones.
// RULE_17: display shift rotates the window circularly over 00 to 4F.
// RULE_18: display position n maps to address n minus one, up to 80.
// RULE_19: host starts each transfer with the operation strobe.
// RULE_20: character pointer wraps 4F to 00 upward and 00 to 4F downward.
// RULE_21: flag stands from acceptance until the internal update ends.
`include "lhp_consts.vh"
module lhp_register_port #(
  parameter EXEC_CYCLES = `LHP_EXEC_CYCLES,
  parameter STORE_CYCLES = `LHP_STORE_CYCLES
) (
  input wire clk_sys,
  input wire rst,
  input wire regSelect,
  input wire readWrite,
  input wire opStrobe,
  input wire [7:0] dataIn,
  output reg [7:0] dataOut,
  output reg dataOe,
  input wire entryIncrement,
  input wire shiftLeft,
  input wire shiftRight,
  input wire [6:0] dispPos,
  output reg [7:0] dispCode,
  input wire [5:0] glyphIndex,
  output reg [7:0] glyphRow,
  output wire internalOpFlag,
  output reg [7:0] commandLatch
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_STORE = 4'h2;
  localparam [3:0] ST_FETCH = 4'h4;
  localparam [3:0] ST_EXEC = 4'h8;
  localparam [`LHP_CNT_W-1:0] EXEC_N = EXEC_CYCLES[`LHP_CNT_W-1:0];
  localparam [`LHP_CNT_W-1:0] STORE_N = STORE_CYCLES[`LHP_CNT_W-1:0];
  localparam [`LHP_CNT_W-1:0] CNT_ONE = 8'h01;
  localparam [`LHP_CNT_W-1:0] CNT_ZERO = 8'h00;

  // step within the active memory, wrapping at its last address
  function [6:0] stepPtr;
    input [6:0] p;
    input up;
    input [6:0] last;
    begin
      if (up)
        stepPtr = (p >= last) ? `LHP_PTR_ZERO : p + `LHP_PTR_ONE;
      else
        stepPtr = (p == `LHP_PTR_ZERO) ? last : p - `LHP_PTR_ONE;
    end
  endfunction

  // circular add over the character memory range
  function [6:0] addWrap;
    input [6:0] a;
    input [6:0] b;
    reg [7:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      if (s >= `LHP_CHAR_DEPTH_8)
        s = s - `LHP_CHAR_DEPTH_8;
      addWrap = s[6:0];
    end
  endfunction

  // two-stage synchronisers for all host pins
  reg rsS1;
  reg rsS2;
  reg rwS1;
  reg rwS2;
  reg strobeS1;
  reg strobeS2;
  reg [7:0] dataS1;
  reg [7:0] dataS2;
  reg strobePrev;

  always @(posedge clk_sys) begin
    if (rst) begin
      rsS1 <= 1'b0;
      rsS2 <= 1'b0;
      rwS1 <= 1'b0;
      rwS2 <= 1'b0;
      strobeS1 <= 1'b0;
      strobeS2 <= 1'b0;
      dataS1 <= `LHP_BYTE_ZERO;
      dataS2 <= `LHP_BYTE_ZERO;
      strobePrev <= 1'b0;
    end else begin
      rsS1 <= regSelect;
      rsS2 <= rsS1;
      rwS1 <= readWrite;
      rwS2 <= rwS1;
      strobeS1 <= opStrobe;
      strobeS2 <= strobeS1;
      dataS1 <= dataIn;
      dataS2 <= dataS1;
      strobePrev <= strobeS2;
    end
  end

  reg [3:0] state;
  reg [3:0] next_state;
  reg [`LHP_CNT_W-1:0] opCount;
  reg [6:0] ramPointer;
  reg selGlyph;
  reg [7:0] dataStagingLatch;
  reg pendingRead;
  reg [6:0] dispBase;

  // a transfer completes on the falling strobe edge
  wire strobeFall = strobePrev & ~strobeS2; // RULE_19
  wire cmdWrite = strobeFall & ~rsS2 & ~rwS2; // RULE_06
  wire dataWrite = strobeFall & rsS2 & ~rwS2;
  wire dataRead = strobeFall & rsS2 & rwS2;

  wire fifoInReady;
  wire fifoOutValid;
  wire [7:0] fifoOutData;
  wire isIdle = (state == ST_IDLE);
  wire busy = ~isIdle | fifoOutValid | pendingRead; // RULE_21
  assign internalOpFlag = busy;

  wire cmdAccept = cmdWrite & ~busy; // RULE_10
  wire dataAccept = dataWrite & fifoInReady & (state != ST_FETCH) & (state != ST_EXEC);
  wire readNow = isIdle & pendingRead & ~cmdAccept;
  wire storeNow = isIdle & fifoOutValid & ~pendingRead & ~cmdAccept;

  wire isSetChar = dataS2[`LHP_CMD_CHAR_BIT];
  wire isSetGlyph = ~dataS2[`LHP_CMD_CHAR_BIT] & dataS2[`LHP_CMD_GLYPH_BIT];
  wire [6:0] ptrLast = selGlyph ? `LHP_GLYPH_LAST : `LHP_CHAR_LAST; // RULE_20
  wire [6:0] ptrStep = stepPtr(ramPointer, entryIncrement, ptrLast); // RULE_14

  lhp_fifo2 #(
    .W(`LHP_DATA_W)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .inData(dataS2),
    .inValid(dataAccept),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(storeNow)
  );

  wire [7:0] charRdA;
  wire [7:0] charRdB;
  wire [7:0] glyphRdA;
  wire [7:0] glyphRdB;
  wire [6:0] dispAddr = addWrap(dispBase, dispPos); // RULE_16 RULE_18

  lhp_mem #(
    .W(`LHP_DATA_W),
    .AW(`LHP_CHAR_AW),
    .DEPTH(`LHP_CHAR_DEPTH)
  ) u_char_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrEn(storeNow & ~selGlyph), // RULE_03 RULE_15
    .wrAddr(ramPointer),
    .wrData(fifoOutData),
    .rdAddrA(ramPointer),
    .rdDataA(charRdA),
    .rdAddrB(dispAddr),
    .rdDataB(charRdB)
  );

  lhp_mem #(
    .W(`LHP_DATA_W),
    .AW(`LHP_GLYPH_AW),
    .DEPTH(`LHP_GLYPH_DEPTH)
  ) u_glyph_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrEn(storeNow & selGlyph), // RULE_03
    .wrAddr(ramPointer[5:0]),
    .wrData(fifoOutData),
    .rdAddrA(ramPointer[5:0]),
    .rdDataA(glyphRdA),
    .rdAddrB(glyphIndex),
    .rdDataB(glyphRdB)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmdAccept)
          next_state = (isSetChar | isSetGlyph) ? ST_FETCH : ST_EXEC; // RULE_04
        else if (readNow)
          next_state = ST_FETCH; // RULE_05
        else if (storeNow)
          next_state = ST_STORE;
      end
      ST_STORE: begin
        if (opCount == CNT_ZERO)
          next_state = ST_IDLE;
      end
      ST_FETCH: begin
        next_state = ST_IDLE;
      end
      ST_EXEC: begin
        if (opCount == CNT_ZERO)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      opCount <= CNT_ZERO;
      ramPointer <= `LHP_PTR_ZERO;
      selGlyph <= 1'b0;
      commandLatch <= `LHP_BYTE_ZERO;
      dataStagingLatch <= `LHP_BYTE_ZERO;
      pendingRead <= 1'b0;
    end else begin
      state <= next_state;
      // a new read wins over the clear of the one being served
      if (dataRead)
        pendingRead <= 1'b1;
      else if (readNow)
        pendingRead <= 1'b0;
      if (isIdle & cmdAccept) begin
        commandLatch <= dataS2; // RULE_01 RULE_06
        if (isSetChar) begin
          ramPointer <= addWrap(dataS2[6:0], `LHP_PTR_ZERO); // RULE_13
          selGlyph <= 1'b0;
        end else if (isSetGlyph) begin
          ramPointer <= {1'b0, dataS2[5:0]}; // RULE_13
          selGlyph <= 1'b1;
        end else begin
          opCount <= EXEC_N - CNT_ONE;
        end
      end else if (readNow) begin
        ramPointer <= ptrStep; // RULE_14
      end else if (storeNow) begin
        dataStagingLatch <= fifoOutData; // RULE_08
        ramPointer <= ptrStep; // RULE_14
        opCount <= STORE_N - CNT_ONE;
      end
      if ((state == ST_STORE) | (state == ST_EXEC)) begin
        if (opCount != CNT_ZERO)
          opCount <= opCount - CNT_ONE;
      end
      if (state == ST_FETCH)
        dataStagingLatch <= selGlyph ? glyphRdA : charRdA; // RULE_04 RULE_05
    end
  end

  // host read path; command latch never reaches the bus
  always @(posedge clk_sys) begin
    if (rst) begin
      dataOut <= `LHP_BYTE_ZERO;
      dataOe <= 1'b0;
    end else begin
      dataOe <= strobeS2 & rwS2;
      if (strobeS2 & rwS2) begin
        if (rsS2)
          dataOut <= dataStagingLatch; // RULE_09
        else
          dataOut <= {busy, ramPointer}; // RULE_02 RULE_07 RULE_12
      end else begin
        dataOut <= `LHP_BYTE_ZERO;
      end
    end
  end

  // display window origin, rotated circularly by shifts
  always @(posedge clk_sys) begin
    if (rst) begin
      dispBase <= `LHP_PTR_ZERO;
      dispCode <= `LHP_BYTE_ZERO;
      glyphRow <= `LHP_BYTE_ZERO;
    end else begin
      if (shiftLeft & ~shiftRight)
        dispBase <= stepPtr(dispBase, 1'b1, `LHP_CHAR_LAST); // RULE_17
      else if (shiftRight & ~shiftLeft)
        dispBase <= stepPtr(dispBase, 1'b0, `LHP_CHAR_LAST); // RULE_17
      dispCode <= charRdB;
      glyphRow <= glyphRdB;
    end
  end
endmodule

/* File: test/lhp_port_checker.sv */
// lhp_port_checker: concurrent checks on the host register port
// assumes bind onto lhp_register_port, one clock, synchronous reset
module lhp_port_checker #(
  parameter EXEC_CYCLES = 4,
  parameter STORE_CYCLES = 3
) (
  input logic clk_sys,
  input logic rst,
  input logic regSelect,
  input logic readWrite,
  input logic opStrobe,
  input logic [7:0] dataOut,
  input logic dataOe,
  input logic internalOpFlag,
  input logic [7:0] commandLatch
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUSY_MAX = EXEC_CYCLES + 2 * STORE_CYCLES + 10;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_resetQuiet;
    $fell(rst) |-> !dataOe && !internalOpFlag && dataOut == 8'h00 && commandLatch == 8'h00;
  endproperty
  a_resetQuiet: assert property (p_resetQuiet) else $error("outputs not clear after reset");
  property p_noDriveOnWrite; (!readWrite) [*4] |-> !dataOe; endproperty
  a_noDriveOnWrite: assert property (p_noDriveOnWrite) else $error("bus driven in a write");
  property p_quietBus; (!opStrobe) [*5] |-> !dataOe && dataOut == 8'h00; endproperty
  a_quietBus: assert property (p_quietBus) else $error("bus active without strobe");
  property p_readDrive; (opStrobe && readWrite) [*5] |-> dataOe; endproperty
  a_readDrive: assert property (p_readDrive) else $error("bus not driven in a read");
  // status byte carries the flag of the previous cycle on bit 7
  property p_statusPtr;
    (opStrobe && readWrite && !regSelect) [*5] |-> dataOut[7] == $past(internalOpFlag) && dataOut[6:0] <= 7'h4f;
  endproperty
  a_statusPtr: assert property (p_statusPtr) else $error("status pointer out of range");
  property p_cmdBusy; $changed(commandLatch) |-> internalOpFlag; endproperty
  a_cmdBusy: assert property (p_cmdBusy) else $error("command taken without busy");
  property p_noCmdWhileBusy; $changed(commandLatch) |-> !$past(internalOpFlag); endproperty
  a_noCmdWhileBusy: assert property (p_noCmdWhileBusy) else $error("command taken while busy");
  property p_busyBounded; $rose(internalOpFlag) |-> ##[1:BUSY_MAX] !internalOpFlag; endproperty
  a_busyBounded: assert property (p_busyBounded) else $error("busy never ended");
  c_cmd: cover property ($changed(commandLatch));
  c_dataRead: cover property ((opStrobe && readWrite && regSelect) [*5]);
  c_busy: cover property ($rose(internalOpFlag));
endmodule

bind lhp_register_port lhp_port_checker #(.EXEC_CYCLES(EXEC_CYCLES), .STORE_CYCLES(STORE_CYCLES)) i_chk (
  .clk_sys(clk_sys), .rst(rst), .regSelect(regSelect), .readWrite(readWrite), .opStrobe(opStrobe),
  .dataOut(dataOut), .dataOe(dataOe), .internalOpFlag(internalOpFlag), .commandLatch(commandLatch));

/* File: test/lhp_host_model.sv */
// lhp_host_model: microprocessor on the 8-bit parallel bus of the port
// assumes pins change at the falling edge of clk_sys
module lhp_host_model (
  input logic clk_sys,
  input logic [7:0] dataOut,
  input logic dataOe,
  output logic regSelect,
  output logic readWrite,
  output logic opStrobe,
  output wire [7:0] dataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic [7:0] hostData = 8'h00;
  // released lines show the inverse of the last byte
  assign dataIn = (dataOe === 1'b1) ? dataOut : (drv ? hostData : ~hostData);
  initial begin
    regSelect = 1'b0;
    readWrite = 1'b1;
    opStrobe = 1'b0;
  end
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    regSelect = rs;
    readWrite = rw;
    hostData = d;
    drv = !rw;
    @(negedge clk_sys);
    opStrobe = 1'b1;
    // sample on the falling edge, where the registered bus has settled
    repeat (5) @(negedge clk_sys);
    q = dataOut;
    opStrobe = 1'b0;
    repeat (5) @(negedge clk_sys);
    drv = 1'b0;
  endtask
  task automatic waitIdle(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
  endtask
endmodule

/* File: test/test_lhp_register_port.sv */
// test_lhp_register_port: self-checking bench of the host register port
// assumes the host model drives the bus pins and the checker is bound
module test_lhp_register_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic entryIncrement = 1'b1;
  logic shiftLeft = 1'b0;
  logic shiftRight = 1'b0;
  logic [6:0] dispPos = 7'h00;
  logic [5:0] glyphIndex = 6'h00;
  wire regSelect, readWrite, opStrobe, dataOe, internalOpFlag;
  wire [7:0] dataIn, dataOut, dispCode, glyphRow, commandLatch;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] q;
  logic ok;
  logic [17:0] rows [16];
  always #5 clk_sys = ~clk_sys;
  lhp_register_port #(.EXEC_CYCLES(60), .STORE_CYCLES(3)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .regSelect(regSelect), .readWrite(readWrite), .opStrobe(opStrobe),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .entryIncrement(entryIncrement),
    .shiftLeft(shiftLeft), .shiftRight(shiftRight), .dispPos(dispPos), .dispCode(dispCode),
    .glyphIndex(glyphIndex), .glyphRow(glyphRow), .internalOpFlag(internalOpFlag), .commandLatch(commandLatch));
  lhp_host_model i_host (
    .clk_sys(clk_sys), .dataOut(dataOut), .dataOe(dataOe), .regSelect(regSelect),
    .readWrite(readWrite), .opStrobe(opStrobe), .dataIn(dataIn));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic idle();
    i_host.waitIdle(ok);
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t: busy never cleared", $time);
      conclude();
    end
  endtask
  task automatic show(input logic [6:0] p, input logic [7:0] exp);
    @(negedge clk_sys);
    dispPos = p;
    repeat (2) @(negedge clk_sys);
    chk(dispCode, exp);
  endtask
  task automatic pulse(input logic left);
    @(negedge clk_sys);
    shiftLeft = left;
    shiftRight = !left;
    @(negedge clk_sys);
    shiftLeft = 1'b0;
    shiftRight = 1'b0;
  endtask
  initial begin
    // {regSelect, readWrite, byte sent, byte expected}
    rows = '{
      {2'b00, 8'hce, 8'h00}, {2'b01, 8'h00, 8'h4e},
      {2'b10, 8'h11, 8'h00}, {2'b10, 8'h22, 8'h00},
      {2'b01, 8'h00, 8'h00}, {2'b10, 8'h33, 8'h00},
      {2'b00, 8'hce, 8'h00}, {2'b11, 8'h00, 8'h11},
      {2'b11, 8'h00, 8'h22}, {2'b11, 8'h00, 8'h33},
      {2'b01, 8'h00, 8'h01}, {2'b00, 8'h45, 8'h00},
      {2'b10, 8'h1f, 8'h00}, {2'b00, 8'h45, 8'h00},
      {2'b11, 8'h00, 8'h1f}, {2'b01, 8'h00, 8'h06}};
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    chk(commandLatch, 8'h00);
    i_host.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h00);
    foreach (rows[i]) begin
      i_host.xfer(rows[i][17], rows[i][16], rows[i][15:8], q);
      if (rows[i][16]) chk(q, rows[i][7:0]);
      idle();
    end
    @(negedge clk_sys);
    glyphIndex = 6'h05;
    repeat (2) @(negedge clk_sys);
    chk(glyphRow, 8'h1f);
    show(7'h00, 8'h33);
    show(7'h4f, 8'h22);
    pulse(1'b0);
    show(7'h00, 8'h22);
    pulse(1'b1);
    pulse(1'b1);
    show(7'h00, 8'h00);
    show(7'h4d, 8'h11);
    entryIncrement = 1'b0;
    i_host.xfer(1'b0, 1'b0, 8'h80, q);
    idle();
    i_host.xfer(1'b1, 1'b0, 8'h44, q);
    idle();
    i_host.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h4f);
    i_host.xfer(1'b0, 1'b0, 8'h01, q);
    i_host.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'hcf);
    chk({7'h00, internalOpFlag}, 8'h01);
    i_host.xfer(1'b0, 1'b0, 8'h02, q);
    idle();
    chk(commandLatch, 8'h01);
    // reset in mid-run clears latch, pointer and memories
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk(commandLatch, 8'h00);
    show(7'h00, 8'h00);
    i_host.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h00);
    conclude();
  end
endmodule
